// [src/tc16_defs.svh]
// register offsets, field positions, reset values and prescale counts
`ifndef TC16_DEFS_SVH
`define TC16_DEFS_SVH

// byte addresses of the registers on the bus
`define OFS_CTRL_A   8'h00
`define OFS_CTRL_B   8'h04
`define OFS_CNT_LO   8'h08
`define OFS_CNT_HI   8'h0C
`define OFS_CMPA_LO  8'h10
`define OFS_CMPA_HI  8'h14
`define OFS_CMPB_LO  8'h18
`define OFS_CMPB_HI  8'h1C
`define OFS_CAP_LO   8'h20
`define OFS_CAP_HI   8'h24
`define OFS_FLAGS    8'h28

// field positions
`define CTRL_A_WGM_LSB 0
`define CTRL_B_SEL_LSB 0
`define CTRL_B_WGM_LSB 3
`define FLAG_OVF_BIT   0

// reset values
`define RST_BYTE  8'h00
`define RST_WORD  16'h0000

// fixed counter limits
`define CNT_MAX   16'hFFFF
`define TOP_8BIT  16'h00FF
`define TOP_9BIT  16'h01FF
`define TOP_10BIT 16'h03FF

// prescaler divide counts, minus one, on a 10-bit divider
`define DIV_8    10'h007
`define DIV_64   10'h03F
`define DIV_256  10'h0FF
`define DIV_1024 10'h3FF

// bus responses
`define RESP_OKAY   2'h0
`define RESP_SLVERR 2'h2

`endif

// [src/tc16_pkg.sv]
// types shared by the 16-bit timer counter block
package tc16_pkg;

    // signals from the bus master
    typedef struct packed {
        logic [7:0] awaddr;
        logic awvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic wvalid;
        logic bready;
        logic [7:0] araddr;
        logic arvalid;
        logic rready;
    } axi_req_t;

    // signals back to the bus master
    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } axi_rsp_t;

    // counter status shown to the waveform logic
    typedef struct packed {
        logic [15:0] count_value;
        logic count_at_top;
        logic count_at_bottom;
        logic overflow_flag;
    } cnt_status_t;

endpackage

// [src/tc16_counter.sv]
// 16-bit timer counter with shared high-byte holding register
`timescale 1ns/1ps
`include "tc16_defs.svh"

// Function
// R01 - one shared 8-bit upper-byte holding register
// R02 - low-byte write loads held byte plus low
// R03 - low-byte read copies upper byte to holder
// R04 - compare reads return both bytes, holder untouched
// R05 - counter upper location accesses the holder
// R06 - software writes high first, reads low first
// R07 - software masks interrupts during two-byte access
// R08 - holder may be reused across several writes
// R09 - counter seen as two 8-bit locations
// R10 - 16-bit counter clears, increments or decrements
// R11 - three-bit tick select, zero stops counter
// R12 - count readable and writable while stopped
// R13 - processor write beats count operations
// R14 - mode field split across both controls
// R15 - top and bottom indications from counter
// R16 - overflow flag set per selected mode
// R17 - max all ones, top fixed or register
// R18 - reset clears count, holder and select
module tc16_counter import tc16_pkg::*; (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire axi_req_t axi_req,
    output axi_rsp_t axi_rsp,
    input wire logic ext_tick_pin,
    output cnt_status_t cnt_status
);

    // -------------------------------------------------------------
    // state
    // -------------------------------------------------------------
    typedef struct packed {
        axi_rsp_t rsp;
        logic [7:0] ctrl_a;
        logic [7:0] ctrl_b;
        logic [7:0] hold;
        logic [15:0] count;
        logic [15:0] cmpa;
        logic [15:0] cmpb;
        logic [15:0] cap;
        logic dir_down;
        logic [9:0] presc;
        logic ext_s1;
        logic ext_s2;
        logic ext_s3;
        cnt_status_t stat;
    } state_t;

    state_t st_reg;
    state_t st_next;

    logic wr_fire;
    logic rd_fire;
    logic [7:0] wbyte;
    logic wr_en;
    logic [2:0] sel;
    logic [3:0] mode;
    logic [15:0] top;
    logic tick;
    logic cnt_write;
    logic ext_rise;
    logic ext_fall;
    logic [15:0] cnt_new;
    logic ovf_set;
    logic rd_ok;
    logic [7:0] rd_byte;

    // -------------------------------------------------------------
    // decode of modes and limits
    // -------------------------------------------------------------
    // mode bits live in both control registers
    assign mode = {st_reg.ctrl_b[`CTRL_B_WGM_LSB +: 2],
                   st_reg.ctrl_a[`CTRL_A_WGM_LSB +: 2]}; // R14
    assign sel = st_reg.ctrl_b[`CTRL_B_SEL_LSB +: 3];

    // sequence top per mode; reserved mode runs like normal
    always_comb begin
        unique case (mode)
            4'd1, 4'd5: top = `TOP_8BIT; // R17
            4'd2, 4'd6: top = `TOP_9BIT;
            4'd3, 4'd7: top = `TOP_10BIT;
            4'd4, 4'd9, 4'd11, 4'd15: top = st_reg.cmpa; // R17
            4'd8, 4'd10, 4'd12, 4'd14: top = st_reg.cap;
            default: top = `CNT_MAX;
        endcase
    end

    // -------------------------------------------------------------
    // tick selection
    // -------------------------------------------------------------
    // edges are taken only from the second and third sync stages
    assign ext_rise = st_reg.ext_s2 & ~st_reg.ext_s3;
    assign ext_fall = ~st_reg.ext_s2 & st_reg.ext_s3;

    always_comb begin
        unique case (sel)
            3'd0: tick = 1'b0; // R11
            3'd1: tick = 1'b1;
            3'd2: tick = (st_reg.presc[2:0] == 3'h7);
            3'd3: tick = (st_reg.presc[5:0] == 6'h3F);
            3'd4: tick = (st_reg.presc[7:0] == 8'hFF);
            3'd5: tick = (st_reg.presc == `DIV_1024);
            3'd6: tick = ext_fall;
            3'd7: tick = ext_rise;
        endcase
    end

    // -------------------------------------------------------------
    // bus handshakes
    // -------------------------------------------------------------
    assign wr_fire = axi_req.awvalid & axi_req.wvalid
                     & st_reg.rsp.awready & st_reg.rsp.wready;
    assign rd_fire = axi_req.arvalid & st_reg.rsp.arready;
    assign wbyte = axi_req.wdata[7:0];
    assign wr_en = wr_fire & axi_req.wstrb[0];
    assign cnt_write = wr_en & (axi_req.awaddr == `OFS_CNT_LO);

    // read data mux; the upper counter and capture bytes come from
    // the holder, compare upper bytes come straight from the register
    always_comb begin
        rd_ok = 1'b1;
        unique case (axi_req.araddr)
            `OFS_CTRL_A: rd_byte = st_reg.ctrl_a;
            `OFS_CTRL_B: rd_byte = st_reg.ctrl_b;
            `OFS_CNT_LO: rd_byte = st_reg.count[7:0]; // R12
            `OFS_CNT_HI: rd_byte = st_reg.hold; // R05 R09
            `OFS_CMPA_LO: rd_byte = st_reg.cmpa[7:0];
            `OFS_CMPA_HI: rd_byte = st_reg.cmpa[15:8]; // R04
            `OFS_CMPB_LO: rd_byte = st_reg.cmpb[7:0];
            `OFS_CMPB_HI: rd_byte = st_reg.cmpb[15:8]; // R04
            `OFS_CAP_LO: rd_byte = st_reg.cap[7:0];
            `OFS_CAP_HI: rd_byte = st_reg.hold;
            `OFS_FLAGS: rd_byte = {7'h00, st_reg.stat.overflow_flag};
            default: begin
                rd_byte = `RST_BYTE;
                rd_ok = 1'b0;
            end
        endcase
    end

    // -------------------------------------------------------------
    // counting step
    // -------------------------------------------------------------
    // phase-correct modes bounce; all others wrap at top
    always_comb begin
        cnt_new = st_reg.count;
        ovf_set = 1'b0;
        if (tick) begin
            unique case (mode)
                4'd1, 4'd2, 4'd3, 4'd8, 4'd9, 4'd10, 4'd11: begin
                    if (st_reg.dir_down) begin
                        cnt_new = (st_reg.count == `RST_WORD)
                                  ? 16'h0001 : st_reg.count - 16'h0001;
                        ovf_set = (st_reg.count == `RST_WORD); // R16
                    end else begin
                        cnt_new = (st_reg.count >= top)
                                  ? st_reg.count - 16'h0001
                                  : st_reg.count + 16'h0001; // R10
                    end
                end
                4'd5, 4'd6, 4'd7, 4'd14, 4'd15: begin
                    cnt_new = (st_reg.count == top) ? `RST_WORD
                              : st_reg.count + 16'h0001;
                    ovf_set = (st_reg.count == top); // R16
                end
                default: begin
                    // normal and clear-on-match: overflow at max
                    cnt_new = (st_reg.count == top) ? `RST_WORD
                              : st_reg.count + 16'h0001; // R10
                    ovf_set = (st_reg.count == `CNT_MAX); // R16
                end
            endcase
        end
    end

    // -------------------------------------------------------------
    // next state
    // -------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        // synchroniser and prescaler
        st_next.ext_s1 = ext_tick_pin;
        st_next.ext_s2 = st_reg.ext_s1;
        st_next.ext_s3 = st_reg.ext_s2;
        st_next.presc = (sel == 3'd0) ? 10'h000
                        : st_reg.presc + 10'h001;

        // write channel: both readies pulse together for one cycle
        st_next.rsp.awready = 1'b0;
        st_next.rsp.wready = 1'b0;
        if (axi_req.awvalid & axi_req.wvalid & ~st_reg.rsp.bvalid
            & ~st_reg.rsp.awready) begin
            st_next.rsp.awready = 1'b1;
            st_next.rsp.wready = 1'b1;
        end
        if (st_reg.rsp.bvalid & axi_req.bready) begin
            st_next.rsp.bvalid = 1'b0;
        end

        // read channel: one ready pulse, data the cycle after
        st_next.rsp.arready = 1'b0;
        if (axi_req.arvalid & ~st_reg.rsp.rvalid
            & ~st_reg.rsp.arready) begin
            st_next.rsp.arready = 1'b1;
        end
        if (st_reg.rsp.rvalid & axi_req.rready) begin
            st_next.rsp.rvalid = 1'b0;
        end

        // counter runs first so a processor write can override it
        st_next.count = cnt_new;
        if (tick) begin
            if (mode inside {4'd1, 4'd2, 4'd3, 4'd8, 4'd9, 4'd10, 4'd11}) begin
                if (st_reg.dir_down & st_reg.count == `RST_WORD) begin
                    st_next.dir_down = 1'b0;
                end else if (~st_reg.dir_down & st_reg.count >= top) begin
                    st_next.dir_down = 1'b1;
                end
            end else begin
                st_next.dir_down = 1'b0;
            end
        end

        // read side effect: low byte copies upper byte into holder
        if (rd_fire) begin
            st_next.rsp.rvalid = 1'b1;
            st_next.rsp.rdata = {24'h000000, rd_byte};
            st_next.rsp.rresp = rd_ok ? `RESP_OKAY : `RESP_SLVERR;
            if (axi_req.araddr == `OFS_CNT_LO) begin
                st_next.hold = st_reg.count[15:8]; // R03
            end else if (axi_req.araddr == `OFS_CAP_LO) begin
                st_next.hold = st_reg.cap[15:8]; // R03
            end
        end

        // writes; a holder write in the same cycle beats the read copy
        if (wr_fire) begin
            st_next.rsp.bvalid = 1'b1;
            st_next.rsp.bresp = rd_ok_w(axi_req.awaddr) ? `RESP_OKAY
                                : `RESP_SLVERR;
        end
        if (wr_en) begin
            unique case (axi_req.awaddr)
                `OFS_CTRL_A: st_next.ctrl_a = wbyte;
                `OFS_CTRL_B: st_next.ctrl_b = wbyte; // R11
                `OFS_CNT_LO: st_next.count = {st_reg.hold, wbyte}; // R02 R13
                `OFS_CMPA_LO: st_next.cmpa = {st_reg.hold, wbyte}; // R02
                `OFS_CMPB_LO: st_next.cmpb = {st_reg.hold, wbyte}; // R02
                `OFS_CAP_LO: begin
                    // capture is writable only when it sets the top
                    if (mode inside {4'd8, 4'd10, 4'd12, 4'd14}) begin
                        st_next.cap = {st_reg.hold, wbyte}; // R02
                    end
                end
                `OFS_CNT_HI, `OFS_CMPA_HI, `OFS_CMPB_HI,
                `OFS_CAP_HI: st_next.hold = wbyte; // R01 R05
                default: ;
            endcase
        end

        // overflow flag: write one clears, a new overflow wins
        if (wr_en & axi_req.awaddr == `OFS_FLAGS
            & wbyte[`FLAG_OVF_BIT]) begin
            st_next.stat.overflow_flag = 1'b0;
        end
        if (ovf_set & ~cnt_write) begin
            st_next.stat.overflow_flag = 1'b1; // R16
        end

        // status outputs follow the next count so they stay aligned
        st_next.stat.count_value = st_next.count;
        st_next.stat.count_at_top = (st_next.count == top); // R15
        st_next.stat.count_at_bottom = (st_next.count == `RST_WORD);
    end

    // write address check, same map as reads
    function automatic logic rd_ok_w(input logic [7:0] a);
        rd_ok_w = (a <= `OFS_FLAGS) & (a[1:0] == 2'b00);
    endfunction

    // -------------------------------------------------------------
    // registers
    // -------------------------------------------------------------
    // every field except the bottom indication resets to zero, so the counter starts stopped
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '0; // R18
            st_reg.stat.count_at_bottom <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign axi_rsp = st_reg.rsp;
    assign cnt_status = st_reg.stat;

    // -------------------------------------------------------------
    // assertions
    // -------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    a_low_write_load: assert property (cnt_write |=> // R02
        st_reg.count == {$past(st_reg.hold), $past(wbyte)})
        else $error("low byte write did not load full count");
    a_write_beats_tick: assert property (cnt_write && tick |=> // R13
        st_reg.count == {$past(st_reg.hold), $past(wbyte)})
        else $error("count step overrode processor write");
    a_low_read_copy: assert property (rd_fire && !wr_fire // R03
        && axi_req.araddr == `OFS_CNT_LO |=>
        st_reg.hold == $past(st_reg.count[15:8]))
        else $error("low byte read did not fill holder");
    a_cmp_read_keep: assert property (rd_fire && !wr_fire // R04
        && axi_req.araddr == `OFS_CMPA_HI |=> $stable(st_reg.hold)
        && st_reg.rsp.rdata[7:0] == $past(st_reg.cmpa[15:8]))
        else $error("compare read disturbed holder");
    a_hi_write_hold: assert property (wr_en // R05
        && axi_req.awaddr == `OFS_CNT_HI |=>
        st_reg.hold == $past(wbyte))
        else $error("upper byte write missed holder");
    a_stop_holds: assert property (sel == 3'd0 && !cnt_write // R11
        |=> st_reg.count == $past(st_reg.count))
        else $error("stopped counter moved");
    a_normal_step: assert property (tick && !cnt_write // R10
        && mode == 4'd0 |=> st_reg.count == $past(st_reg.count)
        + 16'h0001)
        else $error("normal mode did not count up by one");
    a_ovf_at_max: assert property (tick && !cnt_write && mode == 4'd0
        && st_reg.count == `CNT_MAX |=> // R16
        st_reg.stat.overflow_flag ##1 st_reg.stat.overflow_flag
        || $past(wr_en))
        else $error("overflow flag not set at max");
    a_bottom_flag: assert property (st_reg.stat.count_at_bottom == // R15
        (st_reg.count == `RST_WORD))
        else $error("bottom indication wrong");
    a_write_resp: assert property (wr_fire |=> st_reg.rsp.bvalid)
        else $error("write response missing");

    c_count_write: cover property (cnt_write);
    c_low_read: cover property (rd_fire && axi_req.araddr == `OFS_CNT_LO);
    c_overflow: cover property (ovf_set && !cnt_write);
    c_down_turn: cover property (tick && st_reg.dir_down);

endmodule // tc16_counter

// [verif/cpu_bus_model.sv]
// bus master model that stands in for the processor core
`timescale 1ns/1ps
module cpu_bus_model import tc16_pkg::*; (
    input wire logic core_clk,
    input wire axi_rsp_t axi_rsp,
    output axi_req_t axi_req
);
    // --------------------------------------------------------------
    // access tasks
    // --------------------------------------------------------------
    initial begin
        axi_req = '0;
    end

    // one access at a time, so no second access can hit the holder
    // in the middle of a two-byte pair
    task automatic write_reg(input logic [7:0] addr,
        input logic [7:0] data, output logic [1:0] resp);
        logic aw_done;
        logic w_done;
        logic b_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        b_done = 1'b0;
        @(posedge core_clk);
        axi_req.awaddr <= addr;
        axi_req.awvalid <= 1'b1;
        axi_req.wdata <= {24'h000000, data};
        axi_req.wstrb <= 4'hF;
        axi_req.wvalid <= 1'b1;
        axi_req.bready <= 1'b1;
        while (!b_done) begin
            @(posedge core_clk);
            if (aw_done && w_done && axi_rsp.bvalid) begin
                resp = axi_rsp.bresp;
                b_done = 1'b1;
                axi_req.bready <= 1'b0;
            end
            // released payload is inverted so stale data never matches
            if (!aw_done && axi_rsp.awready) begin
                aw_done = 1'b1;
                axi_req.awvalid <= 1'b0;
                axi_req.awaddr <= ~addr;
            end
            if (!w_done && axi_rsp.wready) begin
                w_done = 1'b1;
                axi_req.wvalid <= 1'b0;
                axi_req.wdata <= ~{24'h000000, data};
            end
        end
    endtask

    task automatic read_reg(input logic [7:0] addr,
        output logic [7:0] data, output logic [1:0] resp);
        logic ar_done;
        logic r_done;
        ar_done = 1'b0;
        r_done = 1'b0;
        @(posedge core_clk);
        axi_req.araddr <= addr;
        axi_req.arvalid <= 1'b1;
        axi_req.rready <= 1'b1;
        while (!r_done) begin
            @(posedge core_clk);
            if (ar_done && axi_rsp.rvalid) begin
                data = axi_rsp.rdata[7:0];
                resp = axi_rsp.rresp;
                r_done = 1'b1;
                axi_req.rready <= 1'b0;
            end
            if (!ar_done && axi_rsp.arready) begin
                ar_done = 1'b1;
                axi_req.arvalid <= 1'b0;
                axi_req.araddr <= ~addr;
            end
        end
    endtask
endmodule // cpu_bus_model

// [verif/tb.sv]
// self-checking bench for the 16-bit timer counter
`timescale 1ns/1ps
`include "tc16_defs.svh"
module tb import tc16_pkg::*;;
    logic core_clk;
    logic rst_n;
    logic ext_tick_pin;
    axi_req_t axi_req;
    axi_rsp_t axi_rsp;
    cnt_status_t cnt_status;
    int fail_count;
    int check_count;
    int cycles;
    logic [1:0] resp;
    logic [7:0] rd;
    logic [7:0] exp_hi;
    logic [15:0] mon_exp;
    int sel_wait[5] = '{4, 24, 160, 600, 2100};

    tc16_counter uut (.core_clk(core_clk), .rst_n(rst_n),
        .axi_req(axi_req), .axi_rsp(axi_rsp),
        .ext_tick_pin(ext_tick_pin), .cnt_status(cnt_status));
    cpu_bus_model cpu (.core_clk(core_clk), .axi_rsp(axi_rsp),
        .axi_req(axi_req));

    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    // --------------------------------------------------------------
    // helpers
    // --------------------------------------------------------------
    task automatic check(input string name, input logic [31:0] seen,
        input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        cpu.write_reg(a, d, resp);
    endtask

    task automatic rd_chk(input string name, input logic [7:0] a,
        input logic [7:0] exp);
        cpu.read_reg(a, rd, resp);
        check(name, {24'h0, rd}, {24'h0, exp});
    endtask

    // high byte always goes first so the holder is primed
    task automatic set16(input logic [7:0] hi, input logic [7:0] lo,
        input logic [15:0] v);
        exp_hi = v[15:8];
        wr(hi, v[15:8]);
        wr(lo, v[7:0]);
    endtask

    // run a mode from a start value until overflow rises; the count then
    // and the highest count seen tell the count sequences apart
    task automatic run_to_ovf(input logic [7:0] ca, input logic [7:0] cb,
        input logic [15:0] start, input logic [15:0] exp_end,
        input logic [15:0] exp_peak);
        logic [15:0] peak;
        peak = 16'h0000;
        wr(`OFS_CTRL_B, 8'h00);
        wr(`OFS_FLAGS, 8'h01);
        wr(`OFS_CTRL_A, ca);
        set16(`OFS_CNT_HI, `OFS_CNT_LO, start);
        wr(`OFS_CTRL_B, cb);
        for (int i = 0; i < 600; i++) begin
            @(posedge core_clk);
            #1;
            if (cnt_status.count_value > peak) begin
                peak = cnt_status.count_value;
            end
            if (cnt_status.overflow_flag === 1'b1) break;
        end
        check("seq_end", {16'h0, cnt_status.count_value},
            {16'h0, exp_end});
        check("seq_peak", {16'h0, peak}, {16'h0, exp_peak});
        wr(`OFS_CTRL_B, 8'h00);
        wr(`OFS_CTRL_A, 8'h00);
    endtask

    // the edge taking a low-byte write must show held byte plus data,
    // even when a tick lands on that same edge
    always @(posedge core_clk) begin
        if (axi_rsp.awready && axi_req.awvalid &&
            axi_req.awaddr == `OFS_CNT_LO) begin
            mon_exp = {exp_hi, axi_req.wdata[7:0]};
            #1;
            check("cnt_load", {16'h0, cnt_status.count_value},
                {16'h0, mon_exp});
        end
    end

    // hang guard, far above the few thousand cycles the run needs
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 12000) begin
            fail_count++;
            results();
        end
    end

    // --------------------------------------------------------------
    // main sequence
    // --------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        ext_tick_pin = 1'b0;
        fail_count = 0;
        check_count = 0;
        cycles = 0;
        exp_hi = 8'h00;
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        #1;
        check("rst_cnt", {16'h0, cnt_status.count_value}, 32'h0);
        check("rst_bot", {31'h0, cnt_status.count_at_bottom}, 32'h1);
        rd_chk("rst_lo", `OFS_CNT_LO, 8'h00);
        rd_chk("rst_hi", `OFS_CNT_HI, 8'h00);
        rd_chk("rst_sel", `OFS_CTRL_B, 8'h00);
        // load and read back while stopped
        set16(`OFS_CNT_HI, `OFS_CNT_LO, 16'h1234);
        rd_chk("cnt_lo", `OFS_CNT_LO, 8'h34);
        rd_chk("cnt_hi", `OFS_CNT_HI, 8'h12);
        wr(`OFS_CNT_HI, 8'h56);
        check("hi_only", {16'h0, cnt_status.count_value}, 32'h1234);
        // one held byte serves two registers
        set16(`OFS_CMPA_HI, `OFS_CMPA_LO, 16'hAB01);
        wr(`OFS_CMPB_LO, 8'h02);
        rd_chk("cmpb_hi", `OFS_CMPB_HI, 8'hAB);
        rd_chk("cmpb_lo", `OFS_CMPB_LO, 8'h02);
        rd_chk("cnt_lo2", `OFS_CNT_LO, 8'h34);
        rd_chk("cmpa_hi", `OFS_CMPA_HI, 8'hAB);
        rd_chk("hold_kept", `OFS_CNT_HI, 8'h12);
        // unmapped place
        cpu.write_reg(8'h2C, 8'h5A, resp);
        check("bresp", {30'h0, resp}, {30'h0, `RESP_SLVERR});
        cpu.read_reg(8'h2C, rd, resp);
        check("rresp", {30'h0, resp}, {30'h0, `RESP_SLVERR});
        // mode 0 wraps at all ones and flags overflow on the wrap
        set16(`OFS_CNT_HI, `OFS_CNT_LO, 16'hFFFF);
        check("top_max", {31'h0, cnt_status.count_at_top}, 32'h1);
        set16(`OFS_CNT_HI, `OFS_CNT_LO, 16'hFFF0);
        wr(`OFS_CTRL_B, 8'h01);
        for (int i = 0; i < 40; i++) begin
            @(posedge core_clk);
            #1;
            if (cnt_status.overflow_flag === 1'b1) break;
        end
        check("wrap", {16'h0, cnt_status.count_value}, 32'h0);
        check("bottom", {31'h0, cnt_status.count_at_bottom}, 32'h1);
        set16(`OFS_CNT_HI, `OFS_CNT_LO, 16'h0100);
        wr(`OFS_CTRL_B, 8'h00);
        rd_chk("ovf_set", `OFS_FLAGS, 8'h01);
        wr(`OFS_FLAGS, 8'h01);
        rd_chk("ovf_clr", `OFS_FLAGS, 8'h00);
        // select zero holds the count still
        set16(`OFS_CNT_HI, `OFS_CNT_LO, 16'h0042);
        repeat (20) @(posedge core_clk);
        check("stopped", {16'h0, cnt_status.count_value}, 32'h42);
        // mode bits split over both controls: 12 takes top from capture
        wr(`OFS_CTRL_B, 8'h18);
        set16(`OFS_CAP_HI, `OFS_CAP_LO, 16'h0042);
        // the top indication follows a new top one cycle later
        @(posedge core_clk);
        #1;
        check("top_cap", {31'h0, cnt_status.count_at_top}, 32'h1);
        // dirty the holder so the copy on the low read is seen
        wr(`OFS_CNT_HI, 8'h77);
        rd_chk("cap_lo", `OFS_CAP_LO, 8'h42);
        rd_chk("cap_hi", `OFS_CAP_HI, 8'h00);
        wr(`OFS_CTRL_B, 8'h00);
        @(posedge core_clk);
        #1;
        check("top_m0", {31'h0, cnt_status.count_at_top}, 32'h0);
        // internal tick sources, long enough for one tick at least
        for (int i = 0; i < 5; i++) begin
            set16(`OFS_CNT_HI, `OFS_CNT_LO, 16'h0000);
            wr(`OFS_CTRL_B, 8'(i + 1));
            repeat (sel_wait[i]) @(posedge core_clk);
            wr(`OFS_CTRL_B, 8'h00);
            check("int_tick", {31'h0, cnt_status.count_value != 16'h0},
                32'h1);
        end
        // external pin: falling edges for 6, rising edges for 7
        for (int s = 6; s < 8; s++) begin
            set16(`OFS_CNT_HI, `OFS_CNT_LO, 16'h0000);
            wr(`OFS_CTRL_B, 8'(s));
            repeat (3) begin
                @(posedge core_clk);
                ext_tick_pin <= 1'b1;
                repeat (4) @(posedge core_clk);
                ext_tick_pin <= 1'b0;
                repeat (4) @(posedge core_clk);
            end
            repeat (6) @(posedge core_clk);
            wr(`OFS_CTRL_B, 8'h00);
            check("ext_tick", {16'h0, cnt_status.count_value}, 32'h3);
        end
        // up/down mode 1 turns at 00FF and flags overflow leaving zero
        run_to_ovf(8'h01, 8'h01, 16'h00FD, 16'h0001, 16'h00FF);
        // mode 5 wraps at 00FF and flags overflow on the wrap from top
        run_to_ovf(8'h01, 8'h09, 16'h00F0, 16'h0000, 16'h00FF);
        results();
    end
endmodule // tb
